// >>> hdl/sspb_pkg.sv
// package for the serial port block: modes, rates, carrier structs
// assumes a single 100 MHz system clock
package sspb_pkg;
  localparam int CLK_MHZ = 100;
  // rate select encodings
  localparam logic [2:0] RATE_DIV4 = 3'h0;
  localparam logic [2:0] RATE_DIV16 = 3'h1;
  localparam logic [2:0] RATE_DIV64 = 3'h2;
  localparam logic [2:0] RATE_TMR2 = 3'h3;
  localparam logic [2:0] RATE_BAUD = 3'h4;
  // half-bit counts in system clocks (a bit is two halves)
  localparam logic [7:0] HALF_DIV4 = 8'h02;
  localparam logic [7:0] HALF_DIV16 = 8'h08;
  localparam logic [7:0] HALF_DIV64 = 8'h20;
  localparam logic [6:0] GEN_CALL_ADDR = 7'h00;
  localparam int BIT_COUNT = 8;
  localparam logic [3:0] ACK_CLOCK = 4'h9;
  localparam logic [7:0] BUF_RESET = 8'h00;

  typedef struct packed {
    logic clock_polarity;
    logic clock_edge_select;
    logic input_sample_phase;
    logic [2:0] rate_sel;
  } sspb_spi_cfg_t;

  typedef struct packed {
    logic general_call_enable;
    logic address_hold_enable;
    logic slave_collision_detect_enable;
    logic start_irq_enable;
    logic ten_bit_mode;
    logic ack_value_to_send;
  } sspb_i2c_cfg_t;
endpackage

// >>> hdl/sspb_core.sv
// spi master plus i2c slave transmitter of the synchronous serial port
// assumes pins are already synchronous to mclk_in; software side as plain ports
`timescale 1ns/1ns
// Overview of operation
// - buffer write starts the spi transfer
// - receive-only still loads buffer and flags
// - msb first, polarity from polarity and edge
// - rate from div4/16/64, timer2/2, baud reload
// - edge select presents data before first edge
// - sample point follows sample phase bit, always late when edge select is clear
// - read address match sets rw, acks
// - after read ack, clear release, hold scl
// - software loads buffer, then sets release
// - sda changes on scl falling edges
// - ack captured on ninth rising edge
// - nack ends transfer, irq, go idle
// - ack from master stretches clock again
// - irq flag on ninth falling edge
// - collision sets flag when enabled, idle
// - start sets flag, irq only if enabled
// - buffer read clears buffer full flag
// - restart or stop ends addressing
// - general call acked when enabled
// - general call write raises irq
// - ten-bit general call leaves update-address clear
// - address hold stretches after eighth falling edge
module sspb_core #(
  parameter int DATA_W = 8
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // mode and config
  input wire logic i2c_mode_in,
  input wire sspb_pkg::sspb_spi_cfg_t spi_cfg_in,
  input wire sspb_pkg::sspb_i2c_cfg_t i2c_cfg_in,
  input wire logic [7:0] baud_reload_or_own_address_in,
  input wire logic timer2_tick_in,
  // software buffer access
  input wire logic buf_wr_in,
  input wire logic [DATA_W-1:0] buf_wdata_in,
  input wire logic buf_rd_in,
  input wire logic irq_clear_in,
  input wire logic bcl_clear_in,
  input wire logic clock_release_set_in,
  // receive stream with back-pressure
  input wire logic rx_ready_in,
  output logic rx_valid_out,
  output logic [DATA_W-1:0] rx_data_out,
  output logic tx_ready_out,
  // spi pins
  output logic serial_clock_pin_out,
  output logic serial_out_pin_out,
  input wire logic serial_in_pin_in,
  // i2c pins (open drain: oe high pulls low)
  input wire logic scl_in,
  output logic scl_oe_out,
  input wire logic sda_in,
  output logic sda_oe_out,
  // status
  output logic [DATA_W-1:0] transfer_buffer_out,
  output logic buffer_full_flag_out,
  output logic serial_port_irq_flag_out,
  output logic bus_collision_flag_out,
  output logic master_ack_status_out,
  output logic rw_flag_out,
  output logic start_seen_out,
  output logic update_address_flag_out,
  output logic clock_release_polarity_bit_out,
  output logic busy_out
);
  import sspb_pkg::*;

  typedef enum {SSPB_IDLE, SSPB_ADDR, SSPB_ADDR_ACK, SSPB_HOLD, SSPB_TXD, SSPB_MACK} sspb_st_t;
  sspb_st_t st_reg;

  logic [DATA_W-1:0] serial_shift_register_reg;
  logic [7:0] half_cnt_reg;
  logic [3:0] bit_cnt_reg;
  logic phase_reg;
  logic spi_busy_reg;
  logic tmr_tog_reg;
  logic scl_d_reg, sda_d_reg;
  logic spi_done, byte_event, irq_set;
  logic [7:0] half_lim;
  // two-entry receive buffer
  logic [DATA_W-1:0] fifo_mem [2];
  logic [1:0] fifo_cnt_reg;
  logic fifo_wp_reg, fifo_rp_reg;

  wire scl_rise = scl_in & ~scl_d_reg;
  wire scl_fall = ~scl_in & scl_d_reg;
  wire start_cond = scl_in & scl_d_reg & sda_d_reg & ~sda_in;
  wire stop_cond = scl_in & scl_d_reg & ~sda_d_reg & sda_in;
  wire fifo_push = spi_done;
  wire fifo_pop = rx_valid_out & rx_ready_in;
  wire fifo_room = (fifo_cnt_reg != 2'h2);

  always_comb begin
    case (spi_cfg_in.rate_sel)
      RATE_DIV4: half_lim = HALF_DIV4;
      RATE_DIV16: half_lim = HALF_DIV16;
      RATE_DIV64: half_lim = HALF_DIV64;
      RATE_BAUD: half_lim = 8'((({1'b0, baud_reload_or_own_address_in} + 9'h001) << 1));
      default: half_lim = 8'h01;
    endcase
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      tmr_tog_reg <= 1'b0;
    end else if (timer2_tick_in) begin
      tmr_tog_reg <= ~tmr_tog_reg;
    end
  end

  // timer2 mode steps one half bit per timer2 tick
  wire half_tick = (spi_cfg_in.rate_sel == RATE_TMR2) ? timer2_tick_in
                   : (half_cnt_reg == half_lim - 8'h01);

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      half_cnt_reg <= 8'h00;
    end else if (!spi_busy_reg || half_tick) begin
      half_cnt_reg <= 8'h00;
    end else begin
      half_cnt_reg <= half_cnt_reg + 8'h01;
    end
  end

  assign spi_done = spi_busy_reg & half_tick & phase_reg & (bit_cnt_reg == 4'(BIT_COUNT - 1));
  // refuse a new transfer while the receive buffer is full so no word is lost
  wire spi_start = buf_wr_in & ~i2c_mode_in & ~spi_busy_reg & fifo_room;
  // late sample: trailing edge; with leading-edge output, mid-bit is the trailing edge too
  wire spi_late = spi_cfg_in.input_sample_phase | ~spi_cfg_in.clock_edge_select;
  // last bit lands on the same edge as spi_done when sampling late
  wire [DATA_W-1:0] spi_rx_word = spi_late ?
                                  {serial_shift_register_reg[DATA_W-2:0], serial_in_pin_in} :
                                  serial_shift_register_reg;

  // spi shifter: phase 0 is the leading half of a bit, phase 1 the trailing
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      spi_busy_reg <= 1'b0;
      phase_reg <= 1'b0;
      bit_cnt_reg <= 4'h0;
      serial_shift_register_reg <= '0;
      serial_clock_pin_out <= 1'b0;
      serial_out_pin_out <= 1'b0;
    end else if (spi_start) begin
      spi_busy_reg <= 1'b1;
      phase_reg <= 1'b0;
      bit_cnt_reg <= 4'h0;
      serial_shift_register_reg <= buf_wdata_in;
      serial_out_pin_out <= buf_wdata_in[DATA_W-1];
    end else if (spi_busy_reg && half_tick) begin
      phase_reg <= ~phase_reg;
      serial_clock_pin_out <= ~serial_clock_pin_out;
      if (!phase_reg) begin
        // sample at middle or end of bit
        if (!spi_late) begin
          serial_shift_register_reg <= {serial_shift_register_reg[DATA_W-2:0], serial_in_pin_in};
        end
        if (!spi_cfg_in.clock_edge_select) begin
          serial_out_pin_out <= serial_shift_register_reg[DATA_W-1];
        end
      end else begin
        if (spi_late) begin
          serial_shift_register_reg <= {serial_shift_register_reg[DATA_W-2:0], serial_in_pin_in};
        end
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
        if (spi_cfg_in.clock_edge_select) begin
          serial_out_pin_out <= spi_cfg_in.input_sample_phase ?
                                serial_shift_register_reg[DATA_W-2] :
                                serial_shift_register_reg[DATA_W-1];
        end
        if (bit_cnt_reg == 4'(BIT_COUNT - 1)) begin
          spi_busy_reg <= 1'b0;
        end
      end
    end else if (!spi_busy_reg) begin
      serial_clock_pin_out <= spi_cfg_in.clock_polarity;
    end
  end

  // receive buffer; receive-only use flows through the same path
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      fifo_cnt_reg <= 2'h0;
      fifo_wp_reg <= 1'b0;
      fifo_rp_reg <= 1'b0;
      rx_valid_out <= 1'b0;
      rx_data_out <= '0;
    end else begin
      if (fifo_push) begin
        fifo_mem[fifo_wp_reg] <= spi_rx_word;
        fifo_wp_reg <= ~fifo_wp_reg;
      end
      if (fifo_pop) begin
        fifo_rp_reg <= ~fifo_rp_reg;
      end
      fifo_cnt_reg <= fifo_cnt_reg + {1'b0, fifo_push} - {1'b0, fifo_pop};
      rx_valid_out <= (fifo_cnt_reg + {1'b0, fifo_push} - {1'b0, fifo_pop}) != 2'h0;
      rx_data_out <= (fifo_cnt_reg == 2'h0 || (fifo_pop && fifo_cnt_reg == 2'h1)) ?
                     spi_rx_word :
                     (fifo_pop ? fifo_mem[~fifo_rp_reg] : fifo_mem[fifo_rp_reg]);
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      tx_ready_out <= 1'b0;
      busy_out <= 1'b0;
    end else begin
      tx_ready_out <= ~spi_busy_reg & ~spi_start & (fifo_cnt_reg + {1'b0, fifo_push} != 2'h2);
      busy_out <= spi_busy_reg | spi_start | (st_reg != SSPB_IDLE);
    end
  end

  // i2c pin history
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= scl_in;
      sda_d_reg <= sda_in;
    end
  end

  logic [7:0] i2c_sr_reg;
  logic [3:0] i2c_bit_reg;
  wire addr_gc = (i2c_sr_reg[7:1] == GEN_CALL_ADDR) & i2c_cfg_in.general_call_enable;
  wire addr_me = (i2c_sr_reg[7:1] == baud_reload_or_own_address_in[7:1]);
  wire addr_hit = addr_me | (addr_gc & ~i2c_sr_reg[0]);
  // collision: released sda (driving one) read back low at an scl rising edge
  wire collision = (st_reg == SSPB_TXD) & ~sda_oe_out & scl_rise & ~sda_in;

  // i2c slave sequencer
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      st_reg <= SSPB_IDLE;
      i2c_sr_reg <= 8'h00;
      i2c_bit_reg <= 4'h0;
      scl_oe_out <= 1'b0;
      sda_oe_out <= 1'b0;
      rw_flag_out <= 1'b0;
      master_ack_status_out <= 1'b0;
      clock_release_polarity_bit_out <= 1'b1;
      update_address_flag_out <= 1'b0;
    end else if (!i2c_mode_in) begin
      st_reg <= SSPB_IDLE;
      scl_oe_out <= 1'b0;
      sda_oe_out <= 1'b0;
    end else if (start_cond || stop_cond) begin
      st_reg <= start_cond ? SSPB_ADDR : SSPB_IDLE;
      i2c_bit_reg <= 4'h0;
      scl_oe_out <= 1'b0;
      sda_oe_out <= 1'b0;
    end else begin
      if (clock_release_set_in) begin
        clock_release_polarity_bit_out <= 1'b1;
        scl_oe_out <= 1'b0;
      end
      case (st_reg)
        SSPB_ADDR: begin
          if (scl_rise) begin
            i2c_sr_reg <= {i2c_sr_reg[6:0], sda_in};
            i2c_bit_reg <= i2c_bit_reg + 4'h1;
          end
          if (scl_fall && i2c_bit_reg == 4'h8) begin
            if (addr_hit) begin
              rw_flag_out <= i2c_sr_reg[0];
              // general call never marks the address for update
              update_address_flag_out <= i2c_cfg_in.ten_bit_mode & ~addr_gc;
              if (i2c_cfg_in.address_hold_enable) begin
                scl_oe_out <= 1'b1;
                clock_release_polarity_bit_out <= 1'b0;
              end
              sda_oe_out <= ~(i2c_cfg_in.address_hold_enable & i2c_cfg_in.ack_value_to_send);
              st_reg <= SSPB_ADDR_ACK;
            end else begin
              st_reg <= SSPB_IDLE;
            end
          end
        end
        SSPB_ADDR_ACK: begin
          if (scl_fall) begin
            sda_oe_out <= 1'b0;
            i2c_bit_reg <= 4'h0;
            if (rw_flag_out) begin
              scl_oe_out <= 1'b1;
              clock_release_polarity_bit_out <= 1'b0;
              st_reg <= SSPB_HOLD;
            end else begin
              st_reg <= SSPB_IDLE;
            end
          end
        end
        SSPB_HOLD: begin
          if (clock_release_set_in) begin
            // first data bit goes out in the same cycle that scl is released
            sda_oe_out <= ~i2c_sr_reg[7];
            i2c_bit_reg <= 4'h1;
            st_reg <= SSPB_TXD;
          end
        end
        SSPB_TXD: begin
          if (collision) begin
            sda_oe_out <= 1'b0;
            st_reg <= SSPB_IDLE;
          end else if (scl_fall) begin
            if (i2c_bit_reg == 4'(BIT_COUNT)) begin
              sda_oe_out <= 1'b0;
              st_reg <= SSPB_MACK;
            end else begin
              sda_oe_out <= ~i2c_sr_reg[7 - i2c_bit_reg[2:0]];
              i2c_bit_reg <= i2c_bit_reg + 4'h1;
            end
          end
        end
        SSPB_MACK: begin
          if (scl_rise) begin
            master_ack_status_out <= sda_in;
          end
          if (scl_fall) begin
            if (master_ack_status_out) begin
              st_reg <= SSPB_IDLE;
            end else begin
              scl_oe_out <= 1'b1;
              clock_release_polarity_bit_out <= 1'b0;
              st_reg <= SSPB_HOLD;
            end
          end
        end
        default: ;
      endcase
      if (buf_wr_in && st_reg == SSPB_HOLD) begin
        i2c_sr_reg <= buf_wdata_in;
      end
    end
  end

  // ninth-clock falling edge of a byte that concerns this slave
  assign byte_event = i2c_mode_in & scl_fall & ~start_cond & ~stop_cond &
                      ((st_reg == SSPB_ADDR_ACK) | (st_reg == SSPB_MACK));
  assign irq_set = spi_done | byte_event | (start_cond & i2c_mode_in & i2c_cfg_in.start_irq_enable);

  // sticky flags: set wins over clear
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      serial_port_irq_flag_out <= 1'b0;
      bus_collision_flag_out <= 1'b0;
      start_seen_out <= 1'b0;
      buffer_full_flag_out <= 1'b0;
      transfer_buffer_out <= BUF_RESET;
    end else begin
      serial_port_irq_flag_out <= irq_set | (serial_port_irq_flag_out & ~irq_clear_in);
      bus_collision_flag_out <= (collision & i2c_cfg_in.slave_collision_detect_enable)
                                | (bus_collision_flag_out & ~bcl_clear_in);
      if (start_cond && i2c_mode_in) begin
        start_seen_out <= 1'b1;
      end else if (stop_cond) begin
        start_seen_out <= 1'b0;
      end
      if (spi_done) begin
        transfer_buffer_out <= spi_rx_word;
        buffer_full_flag_out <= 1'b1;
      end else if (i2c_mode_in && st_reg == SSPB_ADDR && scl_fall && i2c_bit_reg == 4'h8
                   && addr_hit) begin
        transfer_buffer_out <= i2c_sr_reg;
        buffer_full_flag_out <= 1'b1;
      end else if (buf_rd_in) begin
        buffer_full_flag_out <= 1'b0;
      end
    end
  end

  // stretch holds scl low until software releases
  hold_release_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    (st_reg == SSPB_HOLD && !clock_release_set_in) |=> scl_oe_out)
    else $error("scl not held while stretching");
  irq_ninth_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    byte_event |=> serial_port_irq_flag_out)
    else $error("irq flag missed ninth falling edge");
  bf_clear_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    (buf_rd_in && !irq_set && !spi_done && !(st_reg == SSPB_ADDR)) |=> !buffer_full_flag_out)
    else $error("buffer full not cleared by read");
  spi_start_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    spi_start |-> spi_run_s)
    else $error("spi did not start on buffer write");
  sequence spi_run_s;
    spi_start ##1 spi_busy_reg;
  endsequence
  spi_msb_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    spi_start |=> serial_out_pin_out == $past(buf_wdata_in[DATA_W-1]))
    else $error("first bit not msb");
  idle_clock_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    (!spi_busy_reg && !spi_start && $stable(spi_cfg_in)
     && $past(!spi_busy_reg)) |=> serial_clock_pin_out == $past(spi_cfg_in.clock_polarity))
    else $error("spi clock not at idle level");
  nack_idle_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    (i2c_mode_in && st_reg == SSPB_MACK && scl_fall && master_ack_status_out
     && !start_cond && !stop_cond) |=> (st_reg == SSPB_IDLE && serial_port_irq_flag_out))
    else $error("nack did not end transfer");
  bcl_flag_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    (i2c_mode_in && collision && i2c_cfg_in.slave_collision_detect_enable && !start_cond
     && !stop_cond) |=> (bus_collision_flag_out && st_reg == SSPB_IDLE))
    else $error("collision not flagged");
  stop_unaddr_a: assert property (@(posedge mclk_in) disable iff (rst_in)
    (i2c_mode_in && stop_cond) |=> st_reg == SSPB_IDLE)
    else $error("still addressed after stop");
endmodule

// >>> sim/sspb_far_end.sv
// far side model: spi slave shifting both ways, plus an i2c bus master
// assumes the block pulls i2c lines low through its enables, pull-ups elsewhere
`timescale 1ns/1ns
module sspb_far_end (
  // clock
  input wire logic mclk_in,
  // spi slave side
  input wire logic sclk_in,
  input wire logic mosi_in,
  input wire logic cpol_in,
  input wire logic cke_in,
  input wire logic [7:0] miso_byte_in,
  output logic miso_out,
  output logic [7:0] mosi_byte_out,
  // i2c master side, wired-and with the block
  input wire logic scl_oe_in,
  input wire logic sda_oe_in,
  output logic scl_out,
  output logic sda_out
);
  logic scl_m = 1'b1;
  logic sda_m = 1'b1;
  logic [3:0] idx = 4'h0;
  initial miso_out = 1'b0;
  initial mosi_byte_out = 8'h00;
  assign scl_out = scl_m & ~scl_oe_in;
  assign sda_out = sda_m & ~sda_oe_in;
  // sample on the leading edge when edge select is set, drive on the other edge
  always @(sclk_in) begin
    if ((sclk_in != cpol_in) == cke_in) begin
      mosi_byte_out <= {mosi_byte_out[6:0], mosi_in};
    end else if (idx < 4'h8) begin
      miso_out <= miso_byte_in[3'h7 - idx[2:0]];
      idx <= idx + 4'h1;
    end
  end
  // no select line: drive the msb before a frame when edge select is set, else flip the line rather than hold stale data
  task automatic spi_arm();
    idx = cke_in ? 4'h1 : 4'h0;
    miso_out = cke_in ? miso_byte_in[7] : ~miso_out;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_in);
  endtask
  // a stretched clock is waited out, but only for a bounded time
  task automatic bit_io(input logic b, output logic seen);
    int w;
    w = 0;
    sda_m <= b;
    tick(8);
    scl_m <= 1'b1;
    tick(1);
    while (scl_out !== 1'b1 && w < 5000) begin
      tick(1);
      w++;
    end
    tick(4);
    seen = sda_out;
    tick(4);
    scl_m <= 1'b0;
    tick(2);
  endtask
  task automatic start();
    sda_m <= 1'b1;
    tick(4);
    scl_m <= 1'b1;
    tick(8);
    sda_m <= 1'b0;
    tick(8);
    scl_m <= 1'b0;
    tick(2);
  endtask
  task automatic stop();
    sda_m <= 1'b0;
    tick(4);
    scl_m <= 1'b1;
    tick(8);
    sda_m <= 1'b1;
    tick(8);
  endtask
  task automatic byte_out(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask
  // clash bits pull sda low where the slave should be sending
  task automatic byte_in(input logic ack, input logic [7:0] clash, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(~clash[i], s);
      d[i] = s;
    end
    bit_io(~ack, s);
  endtask
endmodule

// >>> sim/sspb_core_test.sv
// testbench for the serial port block: spi transfers at every rate, i2c slave reads
// assumes the far side model sspb_far_end and plain-port software access
`timescale 1ns/1ns
module sspb_core_test;
  import sspb_pkg::*;
  localparam int WR = 0, RD = 1, IRQC = 2, BCLC = 3, REL = 4;
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  logic i2c_mode = 1'b0;
  sspb_spi_cfg_t spi_cfg = '0;
  sspb_i2c_cfg_t i2c_cfg = '0;
  logic [7:0] own = 8'h00;
  logic tmr2 = 1'b0;
  logic [4:0] sw = 5'h00;
  logic [7:0] wdata = 8'h00;
  logic rx_ready = 1'b0;
  logic hold_rx = 1'b0;
  logic [7:0] miso_byte = 8'h00;
  logic rx_valid, tx_ready, sclk, dout, din, scl, sda, scl_oe, sda_oe;
  logic full_flag, irq, bcl, ack_stat, rw, start_seen, upd_addr, rel_bit, busy;
  logic [7:0] rx_data, tbuf, mosi_byte;
  logic [7:0] rx_q[$];
  logic [7:0] halves[4] = '{HALF_DIV4, HALF_DIV16, HALF_DIV64, 8'h03};
  int fails = 0;
  int check_count = 0;
  int cyc = 0;
  int t2c = 0;
  always #5 mclk_in = ~mclk_in;
  sspb_core #(.DATA_W(8)) sspb_core_i (
    .mclk_in(mclk_in), .rst_in(rst_in), .i2c_mode_in(i2c_mode), .spi_cfg_in(spi_cfg),
    .i2c_cfg_in(i2c_cfg), .baud_reload_or_own_address_in(own), .timer2_tick_in(tmr2),
    .buf_wr_in(sw[WR]), .buf_wdata_in(wdata), .buf_rd_in(sw[RD]), .irq_clear_in(sw[IRQC]),
    .bcl_clear_in(sw[BCLC]), .clock_release_set_in(sw[REL]), .rx_ready_in(rx_ready),
    .rx_valid_out(rx_valid), .rx_data_out(rx_data), .tx_ready_out(tx_ready),
    .serial_clock_pin_out(sclk), .serial_out_pin_out(dout), .serial_in_pin_in(din),
    .scl_in(scl), .scl_oe_out(scl_oe), .sda_in(sda), .sda_oe_out(sda_oe),
    .transfer_buffer_out(tbuf), .buffer_full_flag_out(full_flag),
    .serial_port_irq_flag_out(irq), .bus_collision_flag_out(bcl),
    .master_ack_status_out(ack_stat), .rw_flag_out(rw), .start_seen_out(start_seen),
    .update_address_flag_out(upd_addr), .clock_release_polarity_bit_out(rel_bit),
    .busy_out(busy));
  sspb_far_end sspb_far_end_i (
    .mclk_in(mclk_in), .sclk_in(sclk), .mosi_in(dout), .cpol_in(spi_cfg.clock_polarity),
    .cke_in(spi_cfg.clock_edge_select), .miso_byte_in(miso_byte), .miso_out(din),
    .mosi_byte_out(mosi_byte), .scl_oe_in(scl_oe), .sda_oe_in(sda_oe), .scl_out(scl),
    .sda_out(sda));
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chkb(input string what, input logic exp, input logic got);
    chk(what, {7'h00, exp}, {7'h00, got});
  endtask
  task automatic pulse(input int k);
    sw[k] <= 1'b1;
    @(posedge mclk_in);
    sw <= 5'h00;
    @(posedge mclk_in);
  endtask
  task automatic waitn(input int n);
    repeat (n) @(posedge mclk_in);
  endtask
  // timer tick every third clock, so its rate gives a three-clock half bit
  always @(posedge mclk_in) begin
    t2c <= (t2c == 2) ? 0 : t2c + 1;
    tmr2 <= (t2c == 2);
  end
  // receive watcher: random stalls, oldest note compared with each popped word
  always @(posedge mclk_in) begin
    cyc <= cyc + 1;
    rx_ready <= ~hold_rx & ($urandom % 2 == 1);
    if (rx_valid === 1'b1 && rx_ready === 1'b1) begin
      if (rx_q.size() == 0) chk("unexpected rx word", 8'h00, rx_data);
      else chk("rx data", rx_q.pop_front(), rx_data);
    end
    if (cyc == 90000) begin
      fails++;
      give_verdict();
    end
  end
  task automatic spi_xfer(input logic [7:0] d, input logic [7:0] sd, input logic [7:0] hx);
    int w;
    int h;
    logic s0;
    w = 0;
    miso_byte <= sd;
    waitn(4);
    while (tx_ready !== 1'b1 && w < 3000) begin
      waitn(1);
      w++;
    end
    sspb_far_end_i.spi_arm();
    rx_q.push_back(sd);
    wdata <= d;
    pulse(WR);
    chkb("busy", 1'b1, busy);
    if (spi_cfg.clock_edge_select) chkb("first bit", d[7], dout);
    s0 = sclk;
    while (sclk === s0 && w < 3000) begin
      waitn(1);
      w++;
    end
    s0 = sclk;
    h = 0;
    while (sclk === s0 && h < 200) begin
      waitn(1);
      h++;
    end
    chk("half bit", hx, h[7:0]);
    while (full_flag !== 1'b1 && w < 3000) begin
      waitn(1);
      w++;
    end
    chk("shifted out", d, mosi_byte);
    chk("buffer", sd, tbuf);
    chkb("irq", 1'b1, irq);
    chkb("idle clock", spi_cfg.clock_polarity, sclk);
    // a write is refused while the receive buffer is full or a transfer is running; only the full case is tried here
    if (hold_rx && rx_q.size() == 2) begin
      wdata <= ~d;
      pulse(WR);
    end
    waitn(4);
    chkb("write while full", 1'b0, busy);
    pulse(RD);
    chkb("full after read", 1'b0, full_flag);
    pulse(IRQC);
  endtask
  initial begin
    logic [7:0] d;
    logic [7:0] got;
    logic [6:0] a;
    logic [2:0] r;
    logic ack;
    void'($urandom(48660));
    waitn(10);
    rst_in <= 1'b0;
    waitn(1);
    chkb("release bit reset", 1'b1, rel_bit);
    for (int i = 0; i < 10; i++) begin
      r = 3'($urandom % 8);
      own <= {5'h00, r};
      hold_rx <= (i >= 8);
      spi_cfg <= '{i[0], ~i[1], i[2], 3'(i % 5)};
      spi_xfer(8'($urandom), 8'($urandom), (i % 5 == 4) ? 8'(2 * (r + 1)) : halves[i % 5]);
    end
    chkb("rx buffer refuses", 1'b0, tx_ready);
    hold_rx <= 1'b0;
    waitn(40);
    chk("rx drained", 8'h00, 8'(rx_q.size()));
    $display("spi test finished");
    a = 7'(1 + $urandom % 126);
    i2c_mode <= 1'b1;
    own <= {a, 1'b0};
    i2c_cfg <= '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
    waitn(4);
    sspb_far_end_i.start();
    chkb("start seen", 1'b1, start_seen);
    chkb("start irq off", 1'b0, irq);
    sspb_far_end_i.byte_out({a, 1'b1}, ack);
    chkb("addr ack", 1'b1, ack);
    chkb("rw flag", 1'b1, rw);
    chk("addr in buffer", {a, 1'b1}, tbuf);
    waitn(30);
    chkb("scl held", 1'b1, scl_oe);
    chkb("release bit", 1'b0, rel_bit);
    chkb("irq on ninth", 1'b1, irq);
    pulse(IRQC);
    pulse(RD);
    chkb("full cleared", 1'b0, full_flag);
    for (int k = 0; k < 2; k++) begin
      d = 8'($urandom);
      fork
        sspb_far_end_i.byte_in(k == 0, 8'h00, got);
        begin
          wdata <= d;
          pulse(WR);
          pulse(REL);
        end
      join
      chk("read byte", d, got);
      chkb("master ack", k[0], ack_stat);
      waitn(30);
      chkb("irq per byte", 1'b1, irq);
      chkb("scl after byte", k == 0, scl_oe);
      pulse(IRQC);
    end
    sspb_far_end_i.byte_in(1'b0, 8'h00, got);
    chk("idle after nack", 8'hff, got);
    sspb_far_end_i.stop();
    i2c_cfg <= '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
    waitn(2);
    sspb_far_end_i.start();
    chkb("start irq on", 1'b1, irq);
    pulse(IRQC);
    sspb_far_end_i.byte_out({a, 1'b1}, ack);
    waitn(30);
    pulse(IRQC);
    pulse(RD);
    fork
      sspb_far_end_i.byte_in(1'b1, 8'h40, got);
      begin
        wdata <= 8'hff;
        pulse(WR);
        pulse(REL);
      end
    join
    chkb("collision flag", 1'b1, bcl);
    chkb("idle after clash", 1'b0, scl_oe);
    pulse(BCLC);
    chkb("collision cleared", 1'b0, bcl);
    for (int g = 0; g < 2; g++) begin
      i2c_cfg <= '{g[0], 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
      pulse(IRQC);
      sspb_far_end_i.start();
      sspb_far_end_i.byte_out(8'h00, ack);
      chkb("general call ack", g[0], ack);
      waitn(30);
      chkb("general call irq", g[0], irq);
      chkb("update address", 1'b0, upd_addr);
      pulse(RD);
    end
    sspb_far_end_i.stop();
    $display("i2c test finished");
    give_verdict();
  end
endmodule
